// ---- dlm_pkg.sv ----
/*
 * Constants and types for the local address and byte-lane mapper.
 * Assumes one chip-select bit (two chips), a 13/2/10 row/bank/column
 * memory and a 16-bit memory data bus.
 */
`default_nettype none
package dlm_pkg;
    localparam int ROW_BITS       = 13;
    localparam int BANK_BITS      = 2;
    localparam int COL_BITS       = 10;
    localparam int CHIP_BITS      = 1;
    localparam int MEM_DQ_BITS    = 16;
    localparam int MEM_BYTES      = MEM_DQ_BITS / 8;
    localparam int FULL_RATIO     = 2;
    localparam int HALF_RATIO     = 4;
    localparam int LOC_DQ_BITS    = MEM_DQ_BITS * HALF_RATIO;
    localparam int LOC_BYTES      = LOC_DQ_BITS / 8;
    localparam int NORM_BITS      = CHIP_BITS + ROW_BITS + BANK_BITS + COL_BITS;
    localparam int ADDR_BITS_FULL = NORM_BITS - 1;
    localparam int ADDR_BITS_HALF = NORM_BITS - 2;
    // field positions inside the normalised memory address
    localparam int COL_LSB        = 0;
    localparam int BANK_LSB_IL    = COL_BITS;
    localparam int ROW_LSB_IL     = COL_BITS + BANK_BITS;
    localparam int ROW_LSB_HI     = COL_BITS;
    localparam int BANK_LSB_HI    = COL_BITS + ROW_BITS;
    localparam int CHIP_LSB       = ROW_BITS + BANK_BITS + COL_BITS;
    localparam logic [2:0] BEATS_FULL = 3'h2;
    localparam logic [2:0] BEATS_HALF = 3'h4;
    localparam logic [2:0] BEATS_NONE = 3'h0;
    localparam logic [2:0] BEATS_ONE  = 3'h1;
    typedef enum logic {DLM_MAP_BANK_IL, DLM_MAP_BANK_HI} dlm_map_t;
    typedef enum logic {DLM_ST_IDLE, DLM_ST_BEATS} dlm_state_t;
endpackage
`default_nettype wire

// ---- dlm_addr_if.sv ----
/*
 * Carrier between the mapper top and its address splitter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface dlm_addr_if import dlm_pkg::*; ();
    logic                      load;
    logic                      half_rate;
    dlm_map_t                  map;
    logic [ADDR_BITS_FULL-1:0] addr;
    logic [CHIP_BITS-1:0]      chip;
    logic [ROW_BITS-1:0]       row;
    logic [BANK_BITS-1:0]      bank;
    logic [COL_BITS-1:0]       col;
    modport src   (output load, half_rate, map, addr, input chip, row, bank, col);
    modport split (input load, half_rate, map, addr, output chip, row, bank, col);
endinterface
`default_nettype wire

// ---- dlm_addr_split.sv ----
/*
 * Splits a local burst address into chip, row, bank and column fields.
 * Assumes load is a one-cycle pulse on the system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module dlm_addr_split import dlm_pkg::*; (
    input wire logic     clk,  // system clock
    input wire logic     rst,  // async reset, active high
    dlm_addr_if.split    ai    // address request and fields
);
    logic [NORM_BITS-1:0] next_norm;

    // local word spans 2 or 4 memory words, so low column bits are zero
    always_comb begin
        if (ai.half_rate) begin
            next_norm = {ai.addr[ADDR_BITS_HALF-1:0], 2'b00};
        end else begin
            next_norm = {ai.addr, 1'b0};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ai.chip <= '0;
            ai.row  <= '0;
            ai.bank <= '0;
            ai.col  <= '0;
        end else if (ai.load) begin
            ai.chip <= next_norm[CHIP_LSB +: CHIP_BITS];
            ai.col  <= next_norm[COL_LSB +: COL_BITS];
            if (ai.map == DLM_MAP_BANK_HI) begin
                ai.row  <= next_norm[ROW_LSB_HI +: ROW_BITS];
                ai.bank <= next_norm[BANK_LSB_HI +: BANK_BITS];
            end else begin
                ai.row  <= next_norm[ROW_LSB_IL +: ROW_BITS];
                ai.bank <= next_norm[BANK_LSB_IL +: BANK_BITS];
            end
        end
    end

    chk_full_field_map: assert property (@(posedge clk) disable iff (rst)
        ai.load && !ai.half_rate && ai.map == DLM_MAP_BANK_IL |=>
        ai.row == $past(ai.addr[23:11]) && ai.bank == $past(ai.addr[10:9]) &&
        ai.col == {$past(ai.addr[8:0]), 1'b0})
        else $error("full-rate field split wrong");

    chk_half_field_map: assert property (@(posedge clk) disable iff (rst)
        ai.load && ai.half_rate && ai.map == DLM_MAP_BANK_IL |=>
        ai.row == $past(ai.addr[22:10]) && ai.bank == $past(ai.addr[9:8]) &&
        ai.col == {$past(ai.addr[7:0]), 2'b00})
        else $error("half-rate field split wrong");

    chk_chip_msb_field: assert property (@(posedge clk) disable iff (rst)
        ai.load |=> ai.chip == ($past(ai.half_rate) ? $past(ai.addr[23]) : $past(ai.addr[24])))
        else $error("chip select not taken from top address bit");

    chk_alt_bank_order: assert property (@(posedge clk) disable iff (rst)
        ai.load && !ai.half_rate && ai.map == DLM_MAP_BANK_HI |=>
        ai.bank == $past(ai.addr[23:22]) && ai.row == $past(ai.addr[21:9]))
        else $error("bank-high ordering wrong");
endmodule // dlm_addr_split
`default_nettype wire

// ---- dlm_map_top.sv ----
/*
 * Local-side address and byte-lane mapper for a DDR3 controller: splits
 * the burst start address and serialises write data and masks onto the
 * 16-bit memory lanes, one memory word per clock.
 * Assumes every input comes from user logic on CLK_SYS, and that the
 * consumer of the beat stream never stalls.
 */
`timescale 1ns/10ps
`default_nettype none
module dlm_map_top import dlm_pkg::*; (
    input  wire logic                      CLK_SYS,             // 10 MHz system clock
    input  wire logic                      SYS_RST,             // async reset, active high
    input  wire logic                      RATE_HALF,           // 1: half-rate, 0: full-rate
    input  wire logic                      MAP_BANK_HI,         // 1: bank above row
    input  wire logic                      REQ_VALID,           // request present
    input  wire logic                      REQ_WRITE,           // 1: write, 0: read
    output logic                           REQ_READY,           // request can be taken
    input  wire logic [ADDR_BITS_FULL-1:0] LOCAL_ADDR,          // burst start address
    input  wire logic [LOC_DQ_BITS-1:0]    WR_DATA,             // local write word
    input  wire logic [LOC_BYTES-1:0]      WR_BYTE_KEEP_HI,     // byte enables, high = write
    output logic                           CMD_VALID,           // fields below are new
    output logic                           CMD_WRITE,           // command is a write
    output logic [CHIP_BITS-1:0]           CMD_CHIP,            // chip select field
    output logic [ROW_BITS-1:0]            CMD_ROW,             // row field
    output logic [BANK_BITS-1:0]           CMD_BANK,            // bank field
    output logic [COL_BITS-1:0]            CMD_COL,             // column field
    output logic                           BEAT_VALID,          // memory word present
    output logic [MEM_DQ_BITS-1:0]         SDRAM_DQ_OUT,        // memory write word
    output logic [MEM_BYTES-1:0]           SDRAM_MASK_LINES_LO  // memory masks, high = skip
);
    dlm_addr_if                 ai ();
    dlm_state_t                 state;
    dlm_state_t                 next_state;
    logic                       take;
    logic [2:0]                 beats_left;
    logic [LOC_DQ_BITS-1:0]     data_sh;
    logic [LOC_BYTES-1:0]       mask_sh;
    logic [LOC_BYTES-1:0]       lane_mask;

    // requests are sampled on the same clock as the user logic, no sync
    assign take = REQ_VALID && REQ_READY;

    // one inverter per byte lane: keep high means mask low
    genvar b;
    generate
        for (b = 0; b < LOC_BYTES; b++) begin : g_lane
            assign lane_mask[b] = ~WR_BYTE_KEEP_HI[b];
        end
    endgenerate

    always_comb begin
        ai.load      = take;
        ai.half_rate = RATE_HALF;
        ai.map       = MAP_BANK_HI ? DLM_MAP_BANK_HI : DLM_MAP_BANK_IL;
        ai.addr      = LOCAL_ADDR;
    end

    dlm_addr_split u_split (
        .clk (CLK_SYS),
        .rst (SYS_RST),
        .ai  (ai.split)
    );

    assign CMD_CHIP = ai.chip;
    assign CMD_ROW  = ai.row;
    assign CMD_BANK = ai.bank;
    assign CMD_COL  = ai.col;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            CMD_VALID <= 1'b0;
            CMD_WRITE <= 1'b0;
        end else begin
            CMD_VALID <= take;
            if (take) begin
                CMD_WRITE <= REQ_WRITE;
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            DLM_ST_IDLE: begin
                if (take && REQ_WRITE) begin
                    next_state = DLM_ST_BEATS;
                end
            end
            DLM_ST_BEATS: begin
                if (beats_left == BEATS_ONE) begin
                    next_state = DLM_ST_IDLE;
                end
            end
            default: begin
                next_state = DLM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            state     <= DLM_ST_IDLE;
            REQ_READY <= 1'b1;
        end else begin
            state     <= next_state;
            REQ_READY <= (next_state == DLM_ST_IDLE);
        end
    end

    // the first beat leaves with the command; the rest follow from the shifter
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            BEAT_VALID          <= 1'b0;
            SDRAM_DQ_OUT        <= '0;
            SDRAM_MASK_LINES_LO <= '1;
            data_sh             <= '0;
            mask_sh             <= '1;
            beats_left          <= BEATS_NONE;
        end else if (take) begin
            BEAT_VALID          <= REQ_WRITE;
            SDRAM_DQ_OUT        <= WR_DATA[MEM_DQ_BITS-1:0];
            SDRAM_MASK_LINES_LO <= lane_mask[MEM_BYTES-1:0];
            data_sh             <= {{MEM_DQ_BITS{1'b0}}, WR_DATA[LOC_DQ_BITS-1:MEM_DQ_BITS]};
            mask_sh             <= {{MEM_BYTES{1'b1}}, lane_mask[LOC_BYTES-1:MEM_BYTES]};
            if (!REQ_WRITE) begin
                beats_left <= BEATS_NONE;
            end else if (RATE_HALF) begin
                beats_left <= BEATS_HALF - BEATS_ONE;
            end else begin
                beats_left <= BEATS_FULL - BEATS_ONE;
            end
        end else if (beats_left != BEATS_NONE) begin
            BEAT_VALID          <= 1'b1;
            SDRAM_DQ_OUT        <= data_sh[MEM_DQ_BITS-1:0];
            SDRAM_MASK_LINES_LO <= mask_sh[MEM_BYTES-1:0];
            data_sh             <= {{MEM_DQ_BITS{1'b0}}, data_sh[LOC_DQ_BITS-1:MEM_DQ_BITS]};
            mask_sh             <= {{MEM_BYTES{1'b1}}, mask_sh[LOC_BYTES-1:MEM_BYTES]};
            beats_left          <= beats_left - BEATS_ONE;
        end else begin
            BEAT_VALID <= 1'b0;
        end
    end

    chk_mask_inverts_keep: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        take && REQ_WRITE |=> SDRAM_MASK_LINES_LO == ~$past(WR_BYTE_KEEP_HI[1:0]))
        else $error("mask lines are not the inverse of byte keep");

    chk_low_half_first: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        take && REQ_WRITE && !RATE_HALF |=> SDRAM_DQ_OUT == $past(WR_DATA[15:0])
        ##1 SDRAM_DQ_OUT == $past(WR_DATA[31:16], 2) &&
        SDRAM_MASK_LINES_LO == ~$past(WR_BYTE_KEEP_HI[3:2], 2))
        else $error("low half of local word not sent first");

    chk_full_two_beats: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        take && REQ_WRITE && !RATE_HALF |=> BEAT_VALID && !REQ_READY ##1 BEAT_VALID && REQ_READY)
        else $error("full-rate write is not two memory words");

    chk_half_four_beats: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        take && REQ_WRITE && RATE_HALF |=> (BEAT_VALID && !REQ_READY)[*3] ##1 (BEAT_VALID && REQ_READY))
        else $error("half-rate write is not four memory words");

    chk_half_last_word: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        take && REQ_WRITE && RATE_HALF |-> ##4 SDRAM_DQ_OUT == $past(WR_DATA[63:48], 4))
        else $error("top quarter of half-rate word not sent last");

    chk_read_no_beats: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        take && !REQ_WRITE |=> CMD_VALID && !CMD_WRITE && !BEAT_VALID && REQ_READY)
        else $error("read produced write data or stalled");

    // the field registers feed the command path directly, so they must not drift
    chk_cmd_after_take: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        take |=> CMD_VALID && CMD_WRITE == $past(REQ_WRITE))
        else $error("command not issued the cycle after a take");

    chk_fields_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !take |=> $stable(CMD_CHIP) && $stable(CMD_ROW) && $stable(CMD_BANK) && $stable(CMD_COL))
        else $error("address fields changed without a take");

    // no stall input downstream: a stray beat would land in memory
    chk_beats_stop: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        REQ_READY && !take |=> !BEAT_VALID)
        else $error("memory word sent with no write pending");

    chk_idle_ready: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !BEAT_VALID |-> REQ_READY)
        else $error("request side stalled with no beats pending");

    chk_write_stalls: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        take && REQ_WRITE |=> !REQ_READY)
        else $error("write did not hold off the next request");

    // first word rides with its command, so the consumer sees both together
    chk_beat_with_cmd: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        CMD_VALID |-> BEAT_VALID == CMD_WRITE)
        else $error("first memory word not sent with its command");

    chk_beat_needs_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        BEAT_VALID |-> CMD_WRITE)
        else $error("memory word sent for a read");

    // half rate spreads the keep bits one byte pair per word, lowest pair first;
    // a swapped pair would still pass the data checks above, hence masks here too
    chk_half_lane_order: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        take && REQ_WRITE && RATE_HALF |=>
        SDRAM_DQ_OUT == $past(WR_DATA[15:0]) && SDRAM_MASK_LINES_LO == ~$past(WR_BYTE_KEEP_HI[1:0])
        ##1 SDRAM_DQ_OUT == $past(WR_DATA[31:16], 2) && SDRAM_MASK_LINES_LO == ~$past(WR_BYTE_KEEP_HI[3:2], 2)
        ##1 SDRAM_DQ_OUT == $past(WR_DATA[47:32], 3) && SDRAM_MASK_LINES_LO == ~$past(WR_BYTE_KEEP_HI[5:4], 3)
        ##1 SDRAM_MASK_LINES_LO == ~$past(WR_BYTE_KEEP_HI[7:6], 4))
        else $error("half-rate lanes or masks out of order");
endmodule // dlm_map_top
`default_nettype wire

// ---- dlm_master_model.sv ----
/*
 * Behavioural user-logic master for the local request side of the mapper.
 * Assumes one clock; drives at the falling edge and holds until a take.
 */
`timescale 1ns/10ps
`default_nettype none
module dlm_master_model import dlm_pkg::*; (
    input  wire logic                      clk,             // system clock
    input  wire logic                      req_ready,       // mapper can take
    output logic                           rate_half,       // rate select
    output logic                           map_bank_hi,     // map order select
    output logic                           req_valid,       // request present
    output logic                           req_write,       // write request
    output logic [ADDR_BITS_FULL-1:0]      local_addr,      // burst start address
    output logic [LOC_DQ_BITS-1:0]         wr_data,         // local write word
    output logic [LOC_BYTES-1:0]           wr_byte_keep_hi  // byte enables
);
    initial begin
        {rate_half, map_bank_hi, req_valid, req_write} = 4'h0;
        local_addr = '0;
        wr_data = '0;
        wr_byte_keep_hi = '0;
    end
    // held lines change only at the falling edge, never before a take
    task automatic send(input logic h, input logic m, input logic w, input logic [ADDR_BITS_FULL-1:0] a,
                        input logic [LOC_DQ_BITS-1:0] d, input logic [LOC_BYTES-1:0] k);
        @(negedge clk);
        {rate_half, map_bank_hi, req_write, req_valid} = {h, m, w, 1'b1};
        local_addr = a;
        wr_data = d;
        wr_byte_keep_hi = k;
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask
    // released lines show a moving pattern, not the last value
    task automatic release_bus;
        req_valid = 1'b0;
        req_write = ~req_write;
        local_addr = ~local_addr;
        wr_data = ~wr_data;
        wr_byte_keep_hi = ~wr_byte_keep_hi;
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clk);
            release_bus();
        end
    endtask
endmodule // dlm_master_model
`default_nettype wire

// ---- tb_top.sv ----
/*
 * Self-checking bench for the mapper: queue model of commands and beats.
 * Assumes the mapper's outputs are registered on the rising edge.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import dlm_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic rate_half, map_bank_hi, req_valid, req_write, req_ready, cmd_valid, cmd_write, beat_valid;
    logic [ADDR_BITS_FULL-1:0] local_addr;
    logic [LOC_DQ_BITS-1:0]    wr_data;
    logic [LOC_BYTES-1:0]      keep;
    logic [CHIP_BITS-1:0]      cmd_chip;
    logic [ROW_BITS-1:0]       cmd_row;
    logic [BANK_BITS-1:0]      cmd_bank;
    logic [COL_BITS-1:0]       cmd_col;
    logic [MEM_DQ_BITS-1:0]    dq;
    logic [MEM_BYTES-1:0]      mask;
    logic [26:0]               cmd_q[$];
    logic [18:0]               beat_q[$];
    int                        n_fail = 0;
    int                        n_tests = 0;
    int                        cyc = 0;
    always #50 clk_sys = ~clk_sys;
    dlm_map_top DUT (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .RATE_HALF(rate_half), .MAP_BANK_HI(map_bank_hi),
        .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_READY(req_ready), .LOCAL_ADDR(local_addr),
        .WR_DATA(wr_data), .WR_BYTE_KEEP_HI(keep), .CMD_VALID(cmd_valid), .CMD_WRITE(cmd_write),
        .CMD_CHIP(cmd_chip), .CMD_ROW(cmd_row), .CMD_BANK(cmd_bank), .CMD_COL(cmd_col),
        .BEAT_VALID(beat_valid), .SDRAM_DQ_OUT(dq), .SDRAM_MASK_LINES_LO(mask));
    dlm_master_model master (.clk(clk_sys), .req_ready(req_ready), .rate_half(rate_half),
        .map_bank_hi(map_bank_hi), .req_valid(req_valid), .req_write(req_write),
        .local_addr(local_addr), .wr_data(wr_data), .wr_byte_keep_hi(keep));
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [26:0] exp, input logic [26:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // expectation from integer slicing, independent of the package offsets
    task automatic req(input logic h, input logic m, input logic w, input logic [24:0] a,
                       input logic [63:0] d, input logic [7:0] k);
        int lo, r, n;
        logic [9:0] col;
        lo = h ? 8 : 9;
        r = int'(a) >> lo;
        col = 10'((int'(a) & ((1 << lo) - 1)) << (10 - lo));
        cmd_q.push_back({w, 1'(r >> 15), m ? 13'(r) : 13'(r >> 2), m ? 2'(r >> 13) : 2'(r), col});
        n = h ? 4 : 2;
        if (w) for (int i = 0; i < n; i++) beat_q.push_back({i == n - 1, ~k[2*i+:2], d[16*i+:16]});
        master.send(h, m, w, a, d, k);
    endtask
    task automatic reset_pulse;
        @(negedge clk_sys);
        sys_rst = 1'b1;
        cmd_q.delete();
        beat_q.delete();
        master.release_bus();
        @(negedge clk_sys);
        check("reset flags", 27'h1c, {22'h0, req_ready, mask, beat_valid, cmd_valid});
        check("reset fields", 27'h0, {cmd_write, cmd_chip, cmd_row, cmd_bank, cmd_col});
        repeat (6) @(negedge clk_sys);
        sys_rst = 1'b0;
    endtask
    // registered outputs read before this edge's updates land
    always @(posedge clk_sys) begin
        cyc++;
        if (!sys_rst && cmd_valid === 1'b1) begin
            if (cmd_q.size() == 0) check("extra command", 27'h0, 27'h1);
            else check("command", cmd_q.pop_front(), {cmd_write, cmd_chip, cmd_row, cmd_bank, cmd_col});
        end
        if (!sys_rst && beat_valid === 1'b1) begin
            if (beat_q.size() == 0) check("extra beat", 27'h0, 27'h1);
            else check("beat", 27'(beat_q.pop_front()), {8'h0, req_ready, mask, dq});
        end
        // the ceiling comes last so that nothing in this process follows the finish
        if (cyc == 5000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'hd06b));
        reset_pulse();
        req(1'b0, 1'b0, 1'b1, 25'h0, 64'h22334455, 8'h0c);
        req(1'b0, 1'b0, 1'b1, 25'h1, 64'h667788aa, 8'h06);
        req(1'b0, 1'b0, 1'b1, 25'h2, 64'hbbccddee, 8'h0a);
        for (int m = 0; m < 16; m++) req(m[0], m[1], m[2], m[3] ? 25'h1ffffff : 25'h0aaaaaa, 64'h0123456789abcdef, 8'h96);
        master.idle(2);
        for (int i = 0; i < 80; i++) begin
            req(1'($urandom), 1'($urandom), 1'($urandom), 25'($urandom), {$urandom, $urandom}, 8'($urandom));
            if ($urandom % 4 == 0) master.idle(1 + $urandom % 3);
        end
        req(1'b1, 1'b0, 1'b1, 25'h1ffffff, 64'h0123456789abcdef, 8'h5a);
        reset_pulse();
        req(1'b0, 1'b1, 1'b0, 25'h1234567, 64'h0, 8'h0);
        master.idle(6);
        check("queues drained", 27'h0, 27'(cmd_q.size() + beat_q.size()));
        conclude();
    end
endmodule // tb_top
`default_nettype wire
